//--- cesc_pkg.sv
// Purpose: shared constants and types for the configuration store and spread control
// Assumes: byte-wide register port at the documented byte offsets
// Notes: nonvolatile array is modelled as an on-chip register image
package cesc_pkg;
    // =====================================================
    // register map
    localparam logic [7:0] CESC_ADDR_BUSY = 8'h18;
    localparam logic [7:0] CESC_ADDR_SPREAD = 8'h19;
    localparam logic [7:0] CESC_ADDR_LEN = 8'h1A;
    localparam int CESC_BUSY_BIT = 7;
    localparam int CESC_LOCK_BIT = 7;
    localparam int CESC_STORE_BIT = 7;
    localparam int CESC_DEPTH_HI = 6;
    localparam int CESC_DEPTH_LO = 4;
    localparam int CESC_RATE_HI = 3;
    localparam int CESC_RATE_LO = 0;
    localparam int CESC_LEN_HI = 6;
    localparam int CESC_LEN_LO = 0;
    // =====================================================
    // reset values
    localparam logic [7:0] CESC_SPREAD_RST = 8'h09;
    localparam logic [7:0] CESC_LEN_RST = 8'h1B;
    localparam logic [2:0] CESC_DEPTH_NONE = 3'h0;
    localparam logic [6:0] CESC_LEN_ZERO = 7'h00;
    // =====================================================
    // store timing
    localparam int CESC_CLK_MHZ = 250;
    localparam int CESC_STORE_US = 10;
    localparam int CESC_STORE_CYC = CESC_STORE_US * CESC_CLK_MHZ;
    localparam int CESC_CNT_W = 16;
    localparam logic [CESC_CNT_W-1:0] CESC_CNT_ONE = 16'h0001;

    typedef enum logic [1:0] {
        CESC_IDLE = 2'b00,
        CESC_BUSY = 2'b01
    } cesc_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cesc_req_t;

    typedef struct packed {
        logic [3:0] rate;
        logic [2:0] depth;
        logic center;
        logic spread_en;
    } cesc_spread_t;
endpackage

//--- cesc_ctrl.sv
// Purpose: nonvolatile store control, permanent lock, block length and spread setup
// Assumes: register requests come from the serial interface decoder, one per cycle
// Notes: store time is a parameter so simulation can shorten it
`timescale 1ns/1ps

// Functional notes
// R1 - busy flag rises when a store begins and falls once it finishes
// R2 - host writes to the busy flag are ignored
// R3 - host must not write during a store; reads stay allowed
// R4 - reading the busy flag returns its live value during a store
// R5 - four-bit rate code selects factor 5680 down to 1660; default 3286
// R6 - modulation rate is vco frequency over the selected factor
// R7 - host bypasses the second loop before changing the rate factor
// R8 - host bypasses the second loop before changing the spread amount
// R9 - depth field bits 6:4 picks none, center or down spread amount
// R10 - zero spread powers down spread logic and holds spread output low
// R11 - lock acts only once stored in the nonvolatile array
// R12 - a stored lock refuses every later store
// R13 - while locked, register writes still apply but never commit
// R14 - length field bits 6:0 sets next block read count; default 27
// R15 - store starts only on a rising edge of the store trigger
// R16 - a steady or rewritten one never starts a store
// R17 - store trigger stays one until the host clears it
// R18 - host writes the store trigger last
// R19 - host should write zero then one to the trigger
// R20 - host must not disturb a store in progress
// R21 - power down keeps the register port and all settings alive
module cesc_ctrl #(
    parameter int STORE_CYC = cesc_pkg::CESC_STORE_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register port
    input wire cesc_pkg::cesc_req_t req,
    output logic [7:0] rdata,
    // power down state
    input wire logic power_down_bit,
    // spread and readback control
    output cesc_pkg::cesc_spread_t spread_cfg,
    output logic [12:0] spread_rate_factor,
    output logic [6:0] block_read_length,
    output logic nv_busy_flag,
    output logic nv_lock_active,
    output logic [7:0] nv_spread_image,
    output logic [7:0] nv_len_image
);
    import cesc_pkg::*;

    logic [7:0] spread_q;
    logic [7:0] len_q;
    logic [7:0] nv_spread_q;
    logic [7:0] nv_len_q;
    logic nv_lock_q;
    logic trig_prev_q;
    cesc_state_t state_q;
    logic [CESC_CNT_W-1:0] cnt_q;
    logic wr_spread;
    logic wr_len;
    logic trig_rise;
    logic store_start;
    logic [CESC_CNT_W-1:0] store_len;

    assign store_len = CESC_CNT_W'(STORE_CYC);

    // =====================================================
    // volatile registers
    // power_down_bit gates nothing here: settings survive power down (see R21)
    assign wr_spread = req.wr && (req.addr == CESC_ADDR_SPREAD);
    assign wr_len = req.wr && (req.addr == CESC_ADDR_LEN);

    always_ff @(posedge clk) begin
        if (reset) begin
            spread_q <= CESC_SPREAD_RST;
        end else if (wr_spread) begin
            spread_q <= req.wdata; // applies even when locked, see R13
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            len_q <= CESC_LEN_RST;
        end else if (wr_len) begin
            len_q <= req.wdata; // trigger bit kept until host clears, see R17
        end
    end

    // =====================================================
    // store trigger and sequencer
    always_ff @(posedge clk) begin
        if (reset) begin
            trig_prev_q <= 1'b0;
        end else begin
            trig_prev_q <= len_q[CESC_STORE_BIT];
        end
    end

    // edge of the stored bit, not the write: rewriting one is no edge (see R15, R16)
    assign trig_rise = len_q[CESC_STORE_BIT] && !trig_prev_q;
    // stored lock blocks every store, volatile lock does not (see R12)
    assign store_start = trig_rise && !nv_lock_q && (state_q == CESC_IDLE);

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= CESC_IDLE;
            cnt_q <= '0;
        end else begin
            case (state_q)
                CESC_IDLE: begin
                    if (store_start) begin
                        state_q <= CESC_BUSY; // see R1
                        cnt_q <= store_len;
                    end
                end
                CESC_BUSY: begin
                    if (cnt_q == CESC_CNT_ONE) begin
                        state_q <= CESC_IDLE; // see R1
                    end
                    cnt_q <= cnt_q - CESC_CNT_ONE;
                end
                default: begin
                    state_q <= CESC_IDLE;
                end
            endcase
        end
    end

    // =====================================================
    // nonvolatile image, captured at the start of a store
    always_ff @(posedge clk) begin
        if (reset) begin
            nv_spread_q <= CESC_SPREAD_RST;
            nv_len_q <= CESC_LEN_RST;
        end else if (store_start) begin
            nv_spread_q <= spread_q;
            nv_len_q <= len_q;
        end
    end

    // lock takes effect only from the stored copy (see R11)
    always_ff @(posedge clk) begin
        if (reset) begin
            nv_lock_q <= 1'b0;
        end else if (store_start && spread_q[CESC_LOCK_BIT]) begin
            nv_lock_q <= 1'b1;
        end
    end

    assign nv_busy_flag = (state_q == CESC_BUSY);
    assign nv_lock_active = nv_lock_q;
    assign nv_spread_image = nv_spread_q;
    assign nv_len_image = nv_len_q;

    // =====================================================
    // readback; busy byte is read only (see R2, R4)
    always_comb begin
        rdata = 8'h00;
        if (req.addr == CESC_ADDR_BUSY) begin
            rdata[CESC_BUSY_BIT] = nv_busy_flag;
        end else if (req.addr == CESC_ADDR_SPREAD) begin
            rdata = spread_q;
        end else if (req.addr == CESC_ADDR_LEN) begin
            rdata = len_q;
        end
    end

    // =====================================================
    // spread configuration
    // the fed-back rate is fvco / factor; the analog side does the divide (see R6)
    always_comb begin
        // factors 5680 down to 1660, written in hex
        case (spread_q[CESC_RATE_HI:CESC_RATE_LO]) // see R5
            4'h0: spread_rate_factor = 13'h1630;
            4'h1: spread_rate_factor = 13'h1524;
            4'h2: spread_rate_factor = 13'h1418;
            4'h3: spread_rate_factor = 13'h130C;
            4'h4: spread_rate_factor = 13'h1200;
            4'h5: spread_rate_factor = 13'h10F4;
            4'h6: spread_rate_factor = 13'h0FE8;
            4'h7: spread_rate_factor = 13'h0EDC;
            4'h8: spread_rate_factor = 13'h0DD0;
            4'h9: spread_rate_factor = 13'h0CD6;
            4'hA: spread_rate_factor = 13'h0BB8;
            4'hB: spread_rate_factor = 13'h0AAC;
            4'hC: spread_rate_factor = 13'h09A0;
            4'hD: spread_rate_factor = 13'h0894;
            4'hE: spread_rate_factor = 13'h0788;
            default: spread_rate_factor = 13'h067C;
        endcase
    end

    always_comb begin
        spread_cfg.rate = spread_q[CESC_RATE_HI:CESC_RATE_LO];
        spread_cfg.depth = spread_q[CESC_DEPTH_HI:CESC_DEPTH_LO]; // see R9
        // codes 1..3 center, 4..7 down
        spread_cfg.center = !spread_q[CESC_DEPTH_HI] && (spread_cfg.depth != CESC_DEPTH_NONE);
        // zero depth powers the spread path down, output low (see R10)
        spread_cfg.spread_en = (spread_cfg.depth != CESC_DEPTH_NONE) && !power_down_bit;
    end

    // zero is not allowed; forced to one so a block read returns something (see R14)
    assign block_read_length = (len_q[CESC_LEN_HI:CESC_LEN_LO] == CESC_LEN_ZERO) ?
        7'h01 : len_q[CESC_LEN_HI:CESC_LEN_LO];

    // =====================================================
    // assertions
    sequence s_store_go;
        store_start;
    endsequence

    a_busy_rises: assert property (@(posedge clk) disable iff (reset) // see R1
        s_store_go |=> nv_busy_flag) else $error("busy did not rise on store");

    a_busy_falls: assert property (@(posedge clk) disable iff (reset) // see R1
        (nv_busy_flag && cnt_q == CESC_CNT_ONE) |=> !nv_busy_flag)
        else $error("busy did not fall at store end");

    a_busy_read: assert property (@(posedge clk) disable iff (reset) // see R4
        (req.addr == CESC_ADDR_BUSY) |-> rdata[CESC_BUSY_BIT] == nv_busy_flag)
        else $error("busy readback wrong");

    a_busy_nowrite: assert property (@(posedge clk) disable iff (reset) // see R2
        (req.wr && req.addr == CESC_ADDR_BUSY && !nv_busy_flag && !store_start)
        |=> !nv_busy_flag) else $error("host write changed busy");

    a_no_level_trig: assert property (@(posedge clk) disable iff (reset) // see R16
        ($past(len_q[CESC_STORE_BIT]) && len_q[CESC_STORE_BIT] && !nv_busy_flag)
        |=> !nv_busy_flag) else $error("store started on steady level");

    a_lock_refuse: assert property (@(posedge clk) disable iff (reset) // see R12
        (nv_lock_q && trig_rise && !nv_busy_flag) |=> !nv_busy_flag)
        else $error("store started while locked");

    a_lock_stored: assert property (@(posedge clk) disable iff (reset) // see R11
        $rose(nv_lock_q) |-> $past(store_start) && $past(spread_q[CESC_LOCK_BIT]))
        else $error("lock set without a store");

    a_locked_write: assert property (@(posedge clk) disable iff (reset) // see R13
        wr_spread |=> spread_q == $past(req.wdata)) else $error("write not applied");

    a_trig_holds: assert property (@(posedge clk) disable iff (reset) // see R17
        (len_q[CESC_STORE_BIT] && !wr_len) |=> len_q[CESC_STORE_BIT])
        else $error("trigger bit cleared by itself");

    a_zero_spread: assert property (@(posedge clk) disable iff (reset) // see R10
        (spread_q[CESC_DEPTH_HI:CESC_DEPTH_LO] == CESC_DEPTH_NONE) |-> !spread_cfg.spread_en)
        else $error("spread enabled at zero depth");

    a_len_nonzero: assert property (@(posedge clk) disable iff (reset) // see R14
        block_read_length != CESC_LEN_ZERO) else $error("block length zero");
endmodule

//--- cesc_host_model.sv
// Purpose: host model that programs the configuration registers byte by byte
// Assumes: requests change on the falling edge, one byte per request
// Notes: idle write data is the inverse of the last byte, so stale data never passes
`timescale 1ns/1ps
module cesc_host_model (
    // clock
    input wire logic clk,
    // register port
    output cesc_pkg::cesc_req_t req,
    input wire logic [7:0] rdata,
    input wire logic nv_busy_flag
);
    import cesc_pkg::*;
    logic bypass_q;
    int late_n;
    initial begin
        req = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};
        bypass_q = 1'b0;
        late_n = 0;
    end
    // ==================================================
    // byte transfers
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        // no writes while a store runs
        while (nv_busy_flag !== 1'b0 && n < 5000) begin
            @(negedge clk);
            n++;
        end
        // a store that never ends is counted by the bench
        if (n == 5000) begin
            late_n++;
            $display("[ERR] t=%0t store wait ran out", $time);
        end
        @(negedge clk);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge clk);
        req.wr = 1'b0;
        req.wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        req.rd = 1'b1;
        req.addr = a;
        // take the byte at the edge, release only after it
        @(posedge clk);
        d = rdata;
        @(negedge clk);
        req.rd = 1'b0;
    endtask
    // ==================================================
    // sequences
    task automatic set_spread(input logic [7:0] d);
        bypass_q = 1'b1;
        wr(CESC_ADDR_SPREAD, d);
        bypass_q = 1'b0;
    endtask
    task automatic store(input logic [6:0] len);
        // zero then one, trigger last
        wr(CESC_ADDR_LEN, {1'b0, len});
        wr(CESC_ADDR_LEN, {1'b1, len});
    endtask
endmodule

//--- config_eeprom_and_ssc_control_tb_top.sv
// Purpose: self-checking bench for store control, lock, length and spread setup
// Assumes: short store time through the parameter
// Notes: every rate code in order; spread depths 0 to 7, then random from a fixed seed
`timescale 1ns/1ps
module config_eeprom_and_ssc_control_tb_top;
    import cesc_pkg::*;
    localparam int STORE_N = 8;
    localparam int FACT[16] = '{5680, 5412, 5144, 4876, 4608, 4340, 4072, 3804,
                                3536, 3286, 3000, 2732, 2464, 2196, 1928, 1660};
    logic clk;
    logic reset;
    logic power_down_bit;
    cesc_req_t req;
    logic [7:0] rdata;
    cesc_spread_t spread_cfg;
    logic [12:0] spread_rate_factor;
    logic [6:0] block_read_length;
    logic nv_busy_flag;
    logic nv_lock_active;
    logic [7:0] nv_spread_image;
    logic [7:0] nv_len_image;
    int err_total;
    int num_checks;
    logic [7:0] v;
    logic [7:0] r;
    cesc_ctrl #(.STORE_CYC(STORE_N)) i_dut (.clk(clk), .reset(reset), .req(req),
        .rdata(rdata), .power_down_bit(power_down_bit), .spread_cfg(spread_cfg),
        .spread_rate_factor(spread_rate_factor), .block_read_length(block_read_length),
        .nv_busy_flag(nv_busy_flag), .nv_lock_active(nv_lock_active),
        .nv_spread_image(nv_spread_image), .nv_len_image(nv_len_image));
    cesc_host_model i_host (.clk(clk), .req(req), .rdata(rdata), .nv_busy_flag(nv_busy_flag));
    // ==================================================
    // checking
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        err_total += i_host.late_n;
        $display("checks=%0d mismatches=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic wait_busy(input logic lvl, input int lim);
        int n;
        n = 0;
        while (nv_busy_flag !== lvl) begin
            if (n == lim) begin
                err_total++;
                $display("[ERR] t=%0t busy wait ran out", $time);
                test_done();
            end
            @(negedge clk);
            n++;
        end
    endtask
    function automatic logic [12:0] exp_factor(input logic [3:0] c);
        return 13'(FACT[c]);
    endfunction
    task automatic chk_spread(input logic [7:0] s, input logic pd);
        chk(spread_rate_factor, exp_factor(s[3:0]));
        chk({spread_cfg.depth, spread_cfg.rate}, s[6:0]);
        chk(spread_cfg.spread_en, s[6:4] != 3'h0 && !pd);
        if (s[6:4] != 3'h0) begin
            chk(spread_cfg.center, !s[6]);
        end
    endtask
    // ==================================================
    // stimulus
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (50000) @(posedge clk);
        err_total++;
        test_done();
    end
    initial begin
        err_total = 0;
        num_checks = 0;
        reset = 1'b1;
        power_down_bit = 1'b0;
        void'($urandom(43));
        repeat (16) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        i_host.rd(CESC_ADDR_SPREAD, r);
        chk(r, CESC_SPREAD_RST);
        i_host.rd(CESC_ADDR_LEN, r);
        chk(r, CESC_LEN_RST);
        chk(block_read_length, 7'h1B);
        chk({nv_busy_flag, nv_lock_active}, 2'b00);
        chk_spread(CESC_SPREAD_RST, 1'b0);
        $display("reset test done");
        for (int c = 0; c < 16; c++) begin
            v = {1'b0, (c < 8) ? 3'(c) : 3'($urandom_range(7)), 4'(c)};
            i_host.set_spread(v);
            chk_spread(v, 1'b0);
        end
        $display("spread test done");
        i_host.wr(CESC_ADDR_BUSY, 8'hFF);
        i_host.rd(CESC_ADDR_BUSY, r);
        chk(r, 8'h00);
        i_host.store(7'h05);
        wait_busy(1'b1, 6);
        i_host.rd(CESC_ADDR_BUSY, r);
        chk(r, 8'h80);
        chk({nv_spread_image, nv_len_image}, {v, 8'h85});
        wait_busy(1'b0, STORE_N + 4);
        i_host.rd(CESC_ADDR_LEN, r);
        chk(r, 8'h85);
        i_host.wr(CESC_ADDR_LEN, 8'h85);
        repeat (6) @(negedge clk);
        chk(nv_busy_flag, 1'b0);
        i_host.wr(CESC_ADDR_LEN, 8'h00);
        i_host.rd(CESC_ADDR_LEN, r);
        chk({r, 1'b0, block_read_length}, 16'h0001);
        $display("store test done");
        i_host.set_spread(8'hB9);
        chk(nv_lock_active, 1'b0);
        i_host.store(7'h10);
        wait_busy(1'b1, 6);
        wait_busy(1'b0, STORE_N + 4);
        chk(nv_lock_active, 1'b1);
        i_host.set_spread(8'h23);
        i_host.store(7'h11);
        repeat (8) @(negedge clk);
        chk({nv_busy_flag, nv_lock_active}, 2'b01);
        chk({nv_spread_image, nv_len_image}, 16'hB990);
        chk_spread(8'h23, 1'b0);
        $display("lock test done");
        power_down_bit = 1'b1;
        @(negedge clk);
        chk_spread(8'h23, 1'b1);
        i_host.rd(CESC_ADDR_LEN, r);
        chk(r, 8'h91);
        $display("power down test done");
        test_done();
    end
endmodule
